/* logic/timer0_count_regs.svh */
`ifndef TIMER0_COUNT_REGS_SVH
`define TIMER0_COUNT_REGS_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define TIMER0_COUNT_IDX_COUNT        8'h01
`define TIMER0_COUNT_IDX_INTCTL       8'h0B
`define TIMER0_COUNT_IDX_OPTION       8'h81
`define TIMER0_COUNT_IDX_PORTA_DIR    8'h85
`define TIMER0_COUNT_IDX_IRQ_STATUS   8'hC0
`define TIMER0_COUNT_IDX_IRQ_MASK     8'hC1

// ==========================================================
// option_control fields
`define TIMER0_COUNT_OPT_SRC_BIT      5
`define TIMER0_COUNT_OPT_EDGE_BIT     4
`define TIMER0_COUNT_OPT_ASN_BIT      3
`define TIMER0_COUNT_OPT_PS_MSB       2
`define TIMER0_COUNT_OPT_PS_LSB       0

// ==========================================================
// interrupt_control fields
`define TIMER0_COUNT_INT_OVF_EN_BIT   5
`define TIMER0_COUNT_INT_OVF_FLAG_BIT 2

// ==========================================================
// irq_status / irq_mask fields
`define TIMER0_COUNT_IRQ_OVF_BIT      0
`define TIMER0_COUNT_IRQ_WDT_BIT      1
`define TIMER0_COUNT_IRQ_W            2

// ==========================================================
// reset values
`define TIMER0_COUNT_RST_COUNT        8'h00
`define TIMER0_COUNT_RST_INTCTL       8'h00
`define TIMER0_COUNT_RST_OPTION       8'hFF
`define TIMER0_COUNT_RST_PORTA_DIR    8'h3F
`define TIMER0_COUNT_PORTA_DIR_MASK   8'h3F

// ==========================================================
// timing
`define TIMER0_COUNT_CYCLE_DIV        4
`define TIMER0_COUNT_WRITE_HOLD       2

`endif

/* logic/timer0_count_pkg.sv */
package timer0_count_pkg;

    // ==========================================================
    // wishbone carriers
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [11:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } timer0_count_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } timer0_count_wb_rsp_t;

endpackage

/* logic/timer0_count_timer.sv */
`timescale 1ns/1ps
`include "timer0_count_regs.svh"

// Overview of operation
// - source bit clear: timer mode, one advance per instruction cycle while the prescaler serves the watchdog.
// - writing the count stops counting for the next two instruction cycles.
// - source bit set: counter advances on external clock pin edges.
// - edge bit clear counts rising edges, set counts falling edges.
// - external clock is synchronised first; advance follows after synchronisation.
// - count wrapping from FF to 00 sets the overflow flag.
// - overflow interrupt request on timer_overflow_irq is masked while its enable bit is clear; irq is gated by irq_mask only.
// - timer stops in sleep, so overflow cannot wake the processor.
// - one 8-bit prescaler serves timer or watchdog, never both.
// - prescaler count is never readable or writable by software.
// - option bits 3:0 hold prescaler assignment and division ratio.
// - assigned to timer, ratios 1:2 to 1:256 in powers of two.
// - assigned to watchdog, ratios 1:1 to 1:128 in powers of two.
// - count writes clear the prescaler while it serves the timer.
// - clear-watchdog clears the prescaler while it serves the watchdog.
// - assignment may be changed any time without reset.
module timer0_count_timer #(
    parameter int CYCLE_DIV = `TIMER0_COUNT_CYCLE_DIV,
    parameter int PRE_W     = 8
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // wishbone slave
    input  wire timer0_count_pkg::timer0_count_wb_req_t wb_req,
    output timer0_count_pkg::timer0_count_wb_rsp_t      wb_rsp,
    // core side
    input  wire logic                  sleep_mode,
    input  wire logic                  clear_watchdog_instruction,
    input  wire logic                  watchdog_tick,
    // pin
    input  wire logic                  timer_external_clock_pin,
    // outputs
    output logic                       timer_overflow_irq,
    output logic                       watchdog_timeout,
    output logic [7:0]                 porta_direction,
    output logic                       irq
);

    // ==========================================================
    // registers
    logic [7:0]              timer0_count_reg;
    logic [7:0]              interrupt_control_reg;
    logic [7:0]              option_control_reg;
    logic [7:0]              porta_direction_reg;
    logic [`TIMER0_COUNT_IRQ_W-1:0]  irq_status_reg;
    logic [`TIMER0_COUNT_IRQ_W-1:0]  irq_mask_reg;
    logic [PRE_W-1:0]        prescaler_reg;
    logic [1:0]              hold_reg;
    logic [7:0]              div_reg;
    logic [2:0]              pin_sync_reg;
    logic [2:0]              wdt_sync_reg;
    logic                    timer_irq_reg;
    logic                    wdt_out_reg;
    logic                    irq_reg;
    timer0_count_pkg::timer0_count_wb_rsp_t  rsp_reg;

    // ==========================================================
    // bus decode
    logic        bus_req;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_idx;
    logic [7:0]  wr_byte;
    logic        wr_count;
    logic        wr_intctl;
    logic        wr_option;
    logic        wr_dir;
    logic        wr_mask;
    logic        rd_status;

    // accesses take effect in the cycle the ack is raised
    assign bus_req   = wb_req.cyc & wb_req.stb & ~rsp_reg.ack;
    assign bus_wr    = bus_req & wb_req.we & wb_req.sel[0];
    assign bus_rd    = bus_req & ~wb_req.we;
    assign bus_idx   = wb_req.adr[9:2];
    assign wr_byte   = wb_req.dat[7:0];
    assign wr_count  = bus_wr && (bus_idx == `TIMER0_COUNT_IDX_COUNT);
    assign wr_intctl = bus_wr && (bus_idx == `TIMER0_COUNT_IDX_INTCTL);
    assign wr_option = bus_wr && (bus_idx == `TIMER0_COUNT_IDX_OPTION);
    assign wr_dir    = bus_wr && (bus_idx == `TIMER0_COUNT_IDX_PORTA_DIR);
    assign wr_mask   = bus_wr && (bus_idx == `TIMER0_COUNT_IDX_IRQ_MASK);
    assign rd_status = bus_rd && (bus_idx == `TIMER0_COUNT_IDX_IRQ_STATUS);

    // ==========================================================
    // option fields
    logic       src_ext;
    logic       edge_fall;
    logic       to_wdog;
    logic [2:0] ratio;

    assign src_ext   = option_control_reg[`TIMER0_COUNT_OPT_SRC_BIT];
    assign edge_fall = option_control_reg[`TIMER0_COUNT_OPT_EDGE_BIT];
    assign to_wdog   = option_control_reg[`TIMER0_COUNT_OPT_ASN_BIT];
    assign ratio     = option_control_reg[`TIMER0_COUNT_OPT_PS_MSB:`TIMER0_COUNT_OPT_PS_LSB];

    // ==========================================================
    // instruction cycle enable
    logic cycle_en;

    assign cycle_en = (div_reg == 8'(CYCLE_DIV - 1));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_reg <= 8'h00;
        end else if (cycle_en) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // ==========================================================
    // pin synchronisers
    // stage 0 feeds only stage 1; edges are taken from stages 1 and 2
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], timer_external_clock_pin};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_sync_reg <= 3'h0;
        end else begin
            wdt_sync_reg <= {wdt_sync_reg[1:0], watchdog_tick};
        end
    end

    logic pin_rise;
    logic pin_fall;
    logic ext_edge;
    logic wdt_event;

    assign pin_rise  = pin_sync_reg[1] & ~pin_sync_reg[2];
    assign pin_fall  = ~pin_sync_reg[1] & pin_sync_reg[2];
    assign ext_edge  = edge_fall ? pin_fall : pin_rise;
    assign wdt_event = wdt_sync_reg[1] & ~wdt_sync_reg[2];

    // ==========================================================
    // source event selection
    logic src_event;

    always_comb begin
        src_event = 1'b0;
        if (!sleep_mode) begin
            if (src_ext) begin
                src_event = ext_edge;
            end else begin
                src_event = cycle_en;
            end
        end
    end

    // ==========================================================
    // shared prescaler
    // the period mask picks how many low prescaler bits must be all ones
    logic [PRE_W-1:0] tmr_mask;
    logic [PRE_W-1:0] wdt_mask;
    logic             pre_event;
    logic             pre_tick;
    logic             pre_clear;

    assign tmr_mask  = PRE_W'((16'h0002 << ratio) - 16'h0001);
    assign wdt_mask  = PRE_W'((16'h0001 << ratio) - 16'h0001);
    assign pre_event = to_wdog ? wdt_event : src_event;
    assign pre_tick  = to_wdog ? ((prescaler_reg & wdt_mask) == wdt_mask)
                               : ((prescaler_reg & tmr_mask) == tmr_mask);
    // a write to the count clears it only while the timer owns it
    assign pre_clear = (wr_count & ~to_wdog)
                     | (clear_watchdog_instruction & to_wdog);

    // prescaler is internal only and never reaches the bus
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescaler_reg <= '0;
        end else if (pre_clear) begin
            prescaler_reg <= '0;
        end else if (pre_event) begin
            prescaler_reg <= prescaler_reg + PRE_W'(1);
        end
    end

    // ==========================================================
    // watchdog postscaled output
    // watchdog gets every tick undivided while the timer owns the prescaler
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_out_reg <= 1'b0;
        end else begin
            wdt_out_reg <= wdt_event & (pre_tick | ~to_wdog);
        end
    end

    // ==========================================================
    // timer advance
    logic advance;
    logic overflow;

    // an advance during the hold window is dropped, not deferred
    assign advance = (hold_reg == 2'h0) & src_event
                   & (to_wdog | pre_tick);
    assign overflow = advance & (timer0_count_reg == 8'hFF);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hold_reg <= 2'h0;
        end else if (wr_count) begin
            hold_reg <= 2'(`TIMER0_COUNT_WRITE_HOLD);
        end else if (cycle_en && hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer0_count_reg <= `TIMER0_COUNT_RST_COUNT;
        end else if (wr_count) begin
            timer0_count_reg <= wr_byte;
        end else if (advance) begin
            timer0_count_reg <= timer0_count_reg + 8'h01;
        end
    end

    // ==========================================================
    // control registers
    // the assignment bit may change at any time; no reset needed
    always_ff @(posedge clk) begin
        if (!resetn) begin
            option_control_reg <= `TIMER0_COUNT_RST_OPTION;
        end else if (wr_option) begin
            option_control_reg <= wr_byte;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            porta_direction_reg <= `TIMER0_COUNT_RST_PORTA_DIR;
        end else if (wr_dir) begin
            porta_direction_reg <= wr_byte & `TIMER0_COUNT_PORTA_DIR_MASK;
        end
    end

    // overflow flag is cleared only by software; a same-cycle set wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            interrupt_control_reg <= `TIMER0_COUNT_RST_INTCTL;
        end else begin
            if (wr_intctl) begin
                interrupt_control_reg <= wr_byte;
            end
            if (overflow) begin
                interrupt_control_reg[`TIMER0_COUNT_INT_OVF_FLAG_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_irq_reg <= 1'b0;
        end else begin
            timer_irq_reg <= interrupt_control_reg[`TIMER0_COUNT_INT_OVF_FLAG_BIT]
                           & interrupt_control_reg[`TIMER0_COUNT_INT_OVF_EN_BIT];
        end
    end

    // ==========================================================
    // interrupt status and mask
    logic [`TIMER0_COUNT_IRQ_W-1:0] irq_events;

    always_comb begin
        irq_events = '0;
        irq_events[`TIMER0_COUNT_IRQ_OVF_BIT] = overflow;
        irq_events[`TIMER0_COUNT_IRQ_WDT_BIT] = wdt_event & (pre_tick | ~to_wdog);
    end

    // read clears, but an event in the same cycle stays set
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_status_reg <= '0;
        end else if (rd_status) begin
            irq_status_reg <= irq_events;
        end else begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_mask_reg <= '0;
        end else if (wr_mask) begin
            irq_mask_reg <= wr_byte[`TIMER0_COUNT_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            // follow the status value being stored, so a set that beats a read is seen
            irq_reg <= |((rd_status ? irq_events : (irq_status_reg | irq_events))
                         & irq_mask_reg);
        end
    end

    // ==========================================================
    // read mux
    logic [7:0] rd_byte;

    always_comb begin
        case (bus_idx)
            `TIMER0_COUNT_IDX_COUNT:      rd_byte = timer0_count_reg;
            `TIMER0_COUNT_IDX_INTCTL:     rd_byte = interrupt_control_reg;
            `TIMER0_COUNT_IDX_OPTION:     rd_byte = option_control_reg;
            `TIMER0_COUNT_IDX_PORTA_DIR:  rd_byte = porta_direction_reg;
            `TIMER0_COUNT_IDX_IRQ_STATUS: rd_byte = 8'(irq_status_reg);
            `TIMER0_COUNT_IDX_IRQ_MASK:   rd_byte = 8'(irq_mask_reg);
            default:              rd_byte = 8'h00;
        endcase
    end

    // single wait state: ack one cycle after the strobe, dropped next
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.ack <= bus_req;
            rsp_reg.dat <= bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ==========================================================
    // outputs
    assign wb_rsp             = rsp_reg;
    assign timer_overflow_irq = timer_irq_reg;
    assign watchdog_timeout   = wdt_out_reg;
    assign porta_direction    = porta_direction_reg;
    assign irq                = irq_reg;

endmodule

/* tb/timer0_count_timer_monitor.sv */
`timescale 1ns/1ps
`include "timer0_count_regs.svh"

// ==========================================================
// port checker for the timer block
module timer0_count_timer_chk #(
    parameter int CYCLE_DIV = 4,
    parameter int PRE_W     = 8
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   resetn,
    // register bus
    input wire timer0_count_pkg::timer0_count_wb_req_t wb_req,
    input wire timer0_count_pkg::timer0_count_wb_rsp_t wb_rsp,
    // core and pin side
    input wire logic                   sleep_mode,
    input wire logic                   clear_watchdog_instruction,
    input wire logic                   watchdog_tick,
    input wire logic                   timer_external_clock_pin,
    input wire logic                   timer_overflow_irq,
    input wire logic                   watchdog_timeout,
    input wire logic [7:0]             porta_direction,
    input wire logic                   irq
);
    logic take;
    logic wr_int;
    logic en_reg;

    // shadow of the overflow enable, so gating is judged from the bus alone
    assign take   = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    assign wr_int = take && wb_req.we && wb_req.sel[0] && wb_req.adr[9:2] == `TIMER0_COUNT_IDX_INTCTL;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_reg <= 1'b0;
        end else if (wr_int) begin
            en_reg <= wb_req.dat[`TIMER0_COUNT_INT_OVF_EN_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ack_follows: assert property (take |=> wb_rsp.ack)
        else $error("request not answered in one cycle");
    a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_rd_upper: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_wr_zero: assert property ((take && wb_req.we) |=> wb_rsp.dat == 32'h00000000)
        else $error("write answer carries data");
    a_irq_gated: assert property ($rose(timer_overflow_irq) |-> $past(en_reg))
        else $error("overflow request rose while disabled");
    a_irq_masked: assert property ((!en_reg) [*2] |-> !timer_overflow_irq)
        else $error("overflow request high while disabled");
    a_flag_held: assert property ($fell(timer_overflow_irq) |-> $past(wr_int, 2))
        else $error("overflow request dropped without a write");
    a_sleep_quiet: assert property ((sleep_mode && !wb_req.cyc) [*4] |=>
        !$rose(timer_overflow_irq))
        else $error("overflow during sleep");
    a_wdt_pulse: assert property (watchdog_timeout |=> !watchdog_timeout)
        else $error("watchdog timeout longer than one cycle");

    c_overflow: cover property ($rose(timer_overflow_irq));
    c_timeout: cover property (watchdog_timeout);
    c_irq: cover property ($rose(irq));
endmodule

bind timer0_count_timer timer0_count_timer_chk #(.CYCLE_DIV(CYCLE_DIV), .PRE_W(PRE_W)) u_chk (
    .clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .sleep_mode(sleep_mode), .clear_watchdog_instruction(clear_watchdog_instruction),
    .watchdog_tick(watchdog_tick), .timer_external_clock_pin(timer_external_clock_pin),
    .timer_overflow_irq(timer_overflow_irq), .watchdog_timeout(watchdog_timeout),
    .porta_direction(porta_direction), .irq(irq));

/* tb/timer0_count_pin_src.sv */
`timescale 1ns/1ps

// ==========================================================
// external clock source: a burst of toggles, then the line holds its level
module timer0_count_pin_src (
    // control
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] toggles,
    input  wire logic [3:0] half,
    // pin side
    output logic            pin,
    output logic            busy
);
    logic [7:0] left_reg;
    logic [3:0] wait_reg;

    initial begin
        pin = 1'b0;
        left_reg = 8'h00;
        wait_reg = 4'h0;
    end

    // half sets the speed; at 1 each level still lasts two clocks
    always @(posedge clk) begin
        if (start) begin
            left_reg <= toggles;
            wait_reg <= half;
        end else if (left_reg != 8'h00) begin
            if (wait_reg == 4'h0) begin
                pin <= ~pin;
                left_reg <= left_reg - 8'h01;
                wait_reg <= half;
            end else begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end

    assign busy = start || left_reg != 8'h00;
endmodule

/* tb/timer0_count_timer_bench.sv */
`timescale 1ns/1ps
`include "timer0_count_regs.svh"

`define CHK(name, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", name, exp, got); \
        end \
    end

// ==========================================================
// bench for the timer block
module timer0_count_timer_bench;
    localparam logic [7:0] I_CNT = `TIMER0_COUNT_IDX_COUNT;
    localparam logic [7:0] I_INT = `TIMER0_COUNT_IDX_INTCTL;
    localparam logic [7:0] I_OPT = `TIMER0_COUNT_IDX_OPTION;
    localparam logic [7:0] I_STS = `TIMER0_COUNT_IDX_IRQ_STATUS;
    logic                   clk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   sleep_mode = 1'b0;
    logic                   clr_wdt = 1'b0;
    logic                   wdt_tick = 1'b0;
    logic                   src_go = 1'b0;
    logic [7:0]             src_n = 8'h00;
    logic                   pin, src_busy, ovf_irq, wdt_out, irq;
    logic [7:0]             porta, rd, r0, sum;
    timer0_count_pkg::timer0_count_wb_req_t req = '0;
    timer0_count_pkg::timer0_count_wb_rsp_t rsp;
    int                     mismatches = 0;
    int                     num_checks = 0;
    int                     wd_n = 0;

    always #2.5 clk = ~clk;

    timer0_count_timer #(.CYCLE_DIV(4), .PRE_W(8)) uut (
        .clk(clk), .resetn(resetn), .wb_req(req), .wb_rsp(rsp), .sleep_mode(sleep_mode),
        .clear_watchdog_instruction(clr_wdt), .watchdog_tick(wdt_tick),
        .timer_external_clock_pin(pin), .timer_overflow_irq(ovf_irq),
        .watchdog_timeout(wdt_out), .porta_direction(porta), .irq(irq));
    timer0_count_pin_src src (.clk(clk), .start(src_go), .toggles(src_n), .half(4'h1),
        .pin(pin), .busy(src_busy));

    always @(posedge clk) if (wdt_out === 1'b1) wd_n++;

    // ==========================================================
    // bus and stimulus tasks
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, {2'b00, idx, 2'b00}, 4'hF, {24'h000000, d}};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        rd = rsp.dat[7:0];
        req <= '0;
        `CHK("bus ack", 1'b1, rsp.ack)
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string name);
        wb(1'b0, idx, 8'h00);
        `CHK(name, exp, rd)
    endtask

    // a count write holds off advances for a while, so let it pass first
    task automatic pulses(input logic [7:0] n);
        repeat (10) @(posedge clk);
        src_n <= n;
        src_go <= 1'b1;
        @(posedge clk);
        src_go <= 1'b0;
        while (src_busy) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask

    task automatic ticks(input int n);
        repeat (2 * n) begin
            repeat (3) @(posedge clk);
            wdt_tick <= ~wdt_tick;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        `CHK("porta reset", 8'h3F, porta)
        rdchk(I_OPT, 8'hFF, "option reset");
        rdchk(I_INT, 8'h00, "intctl reset");
        rdchk(I_CNT, 8'h00, "count reset");
        wb(1'b1, `TIMER0_COUNT_IDX_PORTA_DIR, 8'hC5);
        rdchk(`TIMER0_COUNT_IDX_PORTA_DIR, 8'h05, "porta dir");
        `CHK("porta pins", 8'h05, porta)
        wb(1'b1, 8'h3F, 8'h5A);
        rdchk(8'h3F, 8'h00, "unmapped");
        wb(1'b1, I_OPT, 8'hC8);
        wb(1'b0, I_CNT, 8'h00);
        r0 = rd;
        repeat (29) @(posedge clk);
        wb(1'b0, I_CNT, 8'h00);
        `CHK("timer rate", 8'h08, rd - r0)
        // four write phases against the instruction cycle, one of them on its edge
        sum = 8'h00;
        for (int i = 0; i < 4; i++) begin
            repeat (i + 1) @(posedge clk);
            wb(1'b1, I_CNT, 8'h10);
            repeat (29) @(posedge clk);
            wb(1'b0, I_CNT, 8'h00);
            sum = sum + rd;
        end
        `CHK("held count", 8'h57, sum)
        wb(1'b1, I_INT, 8'h00);
        wb(1'b1, `TIMER0_COUNT_IDX_IRQ_MASK, 8'h01);
        wb(1'b0, I_STS, 8'h00);
        wb(1'b1, I_CNT, 8'hFD);
        repeat (40) @(posedge clk);
        rdchk(I_INT, 8'h04, "overflow flag");
        `CHK("masked request", 1'b0, ovf_irq)
        `CHK("irq line", 1'b1, irq)
        wb(1'b1, I_INT, 8'h24);
        repeat (40) @(posedge clk);
        `CHK("enabled request", 1'b1, ovf_irq)
        wb(1'b1, I_INT, 8'h20);
        repeat (2) @(posedge clk);
        `CHK("cleared request", 1'b0, ovf_irq)
        rdchk(I_STS, 8'h01, "status");
        repeat (2) @(posedge clk);
        `CHK("irq after read", 1'b0, irq)
        for (int r = 0; r < 8; r++) begin
            wb(1'b1, I_OPT, 8'hC0 | 8'(r));
            wb(1'b0, I_CNT, 8'h00);
            r0 = rd;
            repeat ((16 << r) - 3) @(posedge clk);
            wb(1'b0, I_CNT, 8'h00);
            `CHK("ratio", 8'h02, rd - r0)
        end
        wb(1'b1, I_OPT, 8'hE8);
        wb(1'b1, I_CNT, 8'h00);
        pulses(8'h05);
        rdchk(I_CNT, 8'h03, "rising edges");
        wb(1'b1, I_OPT, 8'hF8);
        wb(1'b1, I_CNT, 8'h00);
        pulses(8'h03);
        rdchk(I_CNT, 8'h02, "falling edges");
        sleep_mode <= 1'b1;
        pulses(8'h02);
        sleep_mode <= 1'b0;
        rdchk(I_CNT, 8'h02, "sleep count");
        wb(1'b1, I_OPT, 8'hF0);
        wb(1'b1, I_CNT, 8'h20);
        pulses(8'h02);
        rdchk(I_CNT, 8'h20, "half event");
        wb(1'b1, I_CNT, 8'h40);
        pulses(8'h02);
        rdchk(I_CNT, 8'h40, "prescaler cleared");
        pulses(8'h02);
        rdchk(I_CNT, 8'h41, "second event");
        // empty the prescaler while the timer still owns it, then hand it over
        wb(1'b1, I_CNT, 8'h00);
        for (int r = 0; r < 8; r++) begin
            wb(1'b1, I_OPT, 8'hC8 | 8'(r));
            @(posedge clk);
            clr_wdt <= 1'b1;
            @(posedge clk);
            clr_wdt <= 1'b0;
            wd_n = 0;
            ticks((2 << r) - 1);
            `CHK("timeouts", 1, wd_n)
        end
        wb(1'b1, I_OPT, 8'hC0);
        wd_n = 0;
        ticks(3);
        `CHK("undivided", 3, wd_n)
        wb(1'b0, I_STS, 8'h00);
        `CHK("timeout status", 1'b1, rd[1])
        close_out();
    end
endmodule
